// [src/sss_pkg.sv]
// Package for the sync status supervisor: states, register map, timing constants
package sss_pkg;

  // Quality states, best first; lower code ranks higher
  typedef enum logic [2:0] {
    SSS_LOCKED_REGULATED,
    SSS_SYNCED_HOLDOVER,
    SSS_SYNCED_SIMULATED,
    SSS_CRYSTAL_SYNC_DELAY,
    SSS_CRYSTAL_FREEWHEEL,
    SSS_CRYSTAL_SET_MANUALLY,
    SSS_TIME_INVALID
  } sss_state_type;

  // Receiver report bundle
  typedef struct packed {
    logic [4:0] sats_received;
    logic receiver_sync;
    logic position_changing;
    logic antenna_short;
    logic antenna_open;
    logic crystal_reg_fail;
    logic general_module_fault;
    logic port_setting_fault;
    logic nonvolatile_store_fault;
  } sss_rx_type;

  // Register offsets
  localparam logic [3:0] SSS_REG_CONTROL = 4'h0;
  localparam logic [3:0] SSS_REG_LOCK_DELAY = 4'h1;
  localparam logic [3:0] SSS_REG_HOLDOVER = 4'h2;
  localparam logic [3:0] SSS_REG_THRESHOLD = 4'h3;
  localparam logic [3:0] SSS_REG_STATUS = 4'h4;
  localparam logic [3:0] SSS_REG_ERRORS = 4'h5;
  localparam logic [3:0] SSS_REG_LOCK_REMAIN = 4'h6;
  localparam logic [3:0] SSS_REG_HOLD_REMAIN = 4'h7;
  localparam logic [3:0] SSS_REG_COMMAND = 4'h8;

  // Control register fields
  localparam int SSS_CTRL_FIXED_MODE = 0;
  localparam int SSS_CTRL_OFFSET_SET = 1;
  localparam int SSS_CTRL_DST_SET = 2;
  localparam int SSS_CTRL_SIMULATE = 3;
  localparam int SSS_CTRL_TIME_VALID = 4;
  // Command register fields (write one, self clearing)
  localparam int SSS_CMD_MODULE_RESET = 0;
  localparam int SSS_CMD_FACTORY = 1;
  localparam int SSS_CMD_MANUAL_SET = 2;
  localparam int SSS_CMD_RX_INIT = 3;

  // Error register fields
  localparam int SSS_ERR_GENERAL = 0;
  localparam int SSS_ERR_RX_INIT = 1;
  localparam int SSS_ERR_NO_OFFSET = 2;
  localparam int SSS_ERR_NO_DST = 3;
  localparam int SSS_ERR_PORT = 4;
  localparam int SSS_ERR_CRYSTAL = 5;
  localparam int SSS_ERR_ANT_SHORT = 6;
  localparam int SSS_ERR_ANT_OPEN = 7;
  localparam int SSS_ERR_NVSTORE = 8;
  localparam int SSS_ERR_RAW_DATA = 9;
  localparam int SSS_ERR_WIDTH = 10;

  // Reset values
  localparam logic [4:0] SSS_CONTROL_RESET = 5'h01;
  localparam logic [10:0] SSS_LOCK_DELAY_RESET = 11'h000;
  localparam logic [10:0] SSS_HOLDOVER_RESET = 11'h00a;
  localparam logic [2:0] SSS_THRESHOLD_RESET = 3'h1;

  // Timing
  localparam int SSS_MIN_SATS = 4;
  localparam logic [10:0] SSS_HOLDOVER_MIN = 11'h002;
  localparam logic [10:0] SSS_HOLDOVER_MAX = 11'h5a0;
  localparam int SSS_CLOCK_HZ = 100_000_000;
  localparam int SSS_SECOND_S = 1;
  localparam int SSS_TICK_CYCLES = SSS_CLOCK_HZ * SSS_SECOND_S;
  localparam int SSS_MINUTE_S = 60;
  localparam int SSS_REFRESH_S = 5;
  localparam int SSS_RX_INIT_MIN = 1;
  localparam int SSS_LEAP_MIN = 13;

endpackage

// [src/sss_supervisor.sv]
// Sync status supervisor: state ranking, timers, error collection, status output
`timescale 1ns/1ps

module sss_supervisor #(
  parameter int TICK_CYCLES = sss_pkg::SSS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Receiver reports
  input wire sss_pkg::sss_rx_type rx,
  // Outputs
  output logic status_output,
  output logic error_collected,
  output logic source_reset,
  output logic position_update,
  output sss_pkg::sss_state_type sync_state
);

  logic [4:0] control;
  logic [10:0] lock_delay;
  logic [10:0] holdover;
  logic [2:0] threshold;
  logic [26:0] tick_count;
  logic [5:0] second_count;
  logic [2:0] refresh_count;
  logic [10:0] lock_remain;
  logic [10:0] hold_remain;
  logic [3:0] leap_remain;
  logic [1:0] init_remain;
  logic leap_pending;
  logic was_synced;
  logic [sss_pkg::SSS_ERR_WIDTH-1:0] errors;
  logic [15:0] next_rdata;
  sss_pkg::sss_state_type next_state;

  wire second_tick = (tick_count == 27'(TICK_CYCLES - 1));
  wire minute_tick = second_tick && (second_count == 6'(sss_pkg::SSS_MINUTE_S - 1));
  wire refresh_tick = second_tick && (refresh_count == 3'(sss_pkg::SSS_REFRESH_S - 1));
  wire wr_control = reg_write && (reg_addr == sss_pkg::SSS_REG_CONTROL);
  wire wr_lock = reg_write && (reg_addr == sss_pkg::SSS_REG_LOCK_DELAY);
  wire wr_hold = reg_write && (reg_addr == sss_pkg::SSS_REG_HOLDOVER);
  wire wr_thresh = reg_write && (reg_addr == sss_pkg::SSS_REG_THRESHOLD);
  wire wr_cmd = reg_write && (reg_addr == sss_pkg::SSS_REG_COMMAND);
  wire cmd_module_reset = wr_cmd && reg_wdata[sss_pkg::SSS_CMD_MODULE_RESET];
  wire cmd_factory = wr_cmd && reg_wdata[sss_pkg::SSS_CMD_FACTORY];
  wire cmd_manual = wr_cmd && reg_wdata[sss_pkg::SSS_CMD_MANUAL_SET];
  wire cmd_rx_init = wr_cmd && reg_wdata[sss_pkg::SSS_CMD_RX_INIT];
  wire fixed_mode = control[sss_pkg::SSS_CTRL_FIXED_MODE];
  wire simulate = control[sss_pkg::SSS_CTRL_SIMULATE];
  wire time_valid = control[sss_pkg::SSS_CTRL_TIME_VALID];
  wire sats_ok = (rx.sats_received >= 5'(sss_pkg::SSS_MIN_SATS));
  wire receiving = (rx.sats_received != 5'h00);
  wire hold_ok = (reg_wdata[10:0] >= sss_pkg::SSS_HOLDOVER_MIN) &&
                 (reg_wdata[10:0] <= sss_pkg::SSS_HOLDOVER_MAX);
  wire withhold = (fixed_mode && rx.position_changing) || leap_pending ||
                  !control[sss_pkg::SSS_CTRL_OFFSET_SET] || !control[sss_pkg::SSS_CTRL_DST_SET];
  wire rx_synced = rx.receiver_sync && sats_ok && !withhold;
  assign position_update = fixed_mode && sats_ok;
  assign source_reset = cmd_module_reset;

  // Live error vector, sampled on the refresh tick
  logic [sss_pkg::SSS_ERR_WIDTH-1:0] live_errors;
  always_comb begin
    live_errors = '0;
    live_errors[sss_pkg::SSS_ERR_GENERAL] = rx.general_module_fault;
    live_errors[sss_pkg::SSS_ERR_RX_INIT] = (init_remain != 2'h0);
    live_errors[sss_pkg::SSS_ERR_NO_OFFSET] = !control[sss_pkg::SSS_CTRL_OFFSET_SET];
    live_errors[sss_pkg::SSS_ERR_NO_DST] = !control[sss_pkg::SSS_CTRL_DST_SET];
    live_errors[sss_pkg::SSS_ERR_PORT] = rx.port_setting_fault;
    live_errors[sss_pkg::SSS_ERR_CRYSTAL] = rx.crystal_reg_fail;
    live_errors[sss_pkg::SSS_ERR_ANT_SHORT] = rx.antenna_short;
    live_errors[sss_pkg::SSS_ERR_ANT_OPEN] = rx.antenna_open;
    live_errors[sss_pkg::SSS_ERR_NVSTORE] = rx.nonvolatile_store_fault;
    live_errors[sss_pkg::SSS_ERR_RAW_DATA] = leap_pending && receiving;
  end

  assign error_collected = |errors;

  // Timebase
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tick_count <= '0;
      second_count <= '0;
      refresh_count <= '0;
    end else begin
      tick_count <= second_tick ? '0 : tick_count + 27'h1;
      if (second_tick) begin
        second_count <= minute_tick ? '0 : second_count + 6'h01;
        refresh_count <= refresh_tick ? '0 : refresh_count + 3'h1;
      end
    end
  end

  // Configuration; module reset leaves it untouched
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      control <= sss_pkg::SSS_CONTROL_RESET;
      lock_delay <= sss_pkg::SSS_LOCK_DELAY_RESET;
      holdover <= sss_pkg::SSS_HOLDOVER_RESET;
      threshold <= sss_pkg::SSS_THRESHOLD_RESET;
    end else begin
      if (wr_control) begin
        control <= reg_wdata[4:0];
      end
      if (wr_lock) begin
        lock_delay <= reg_wdata[10:0];
      end
      if (wr_hold && hold_ok) begin
        holdover <= reg_wdata[10:0];
      end
      if (wr_thresh && (reg_wdata[2:0] <= 3'(sss_pkg::SSS_TIME_INVALID))) begin
        threshold <= reg_wdata[2:0];
      end
      // Factory restore clears time zone and daylight_saving entries
      if (cmd_factory) begin
        control[sss_pkg::SSS_CTRL_OFFSET_SET] <= 1'b0;
        control[sss_pkg::SSS_CTRL_DST_SET] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      errors <= '0;
    end else if (refresh_tick) begin
      errors <= live_errors;
    end
  end

  // leap acquisition counts only minutes with reception
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      leap_pending <= 1'b0;
      leap_remain <= '0;
    end else if (cmd_factory) begin
      leap_pending <= 1'b1;
      leap_remain <= 4'(sss_pkg::SSS_LEAP_MIN);
    end else if (leap_pending && minute_tick && receiving) begin
      leap_remain <= leap_remain - 4'h1;
      leap_pending <= (leap_remain != 4'h1);
    end
  end

  // init flag ends after one full minute boundary at most
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      init_remain <= '0;
    end else if (cmd_rx_init || cmd_module_reset) begin
      init_remain <= 2'(sss_pkg::SSS_RX_INIT_MIN);
    end else if (minute_tick && (init_remain != 2'h0)) begin
      init_remain <= init_remain - 2'h1;
    end
  end

  // State transitions
  always_comb begin
    next_state = sync_state;
    unique case (sync_state)
      sss_pkg::SSS_LOCKED_REGULATED, sss_pkg::SSS_SYNCED_SIMULATED: begin
        if (simulate) begin
          next_state = sss_pkg::SSS_SYNCED_SIMULATED;
        end else if (!rx_synced) begin
          next_state = sss_pkg::SSS_SYNCED_HOLDOVER;
        end else begin
          next_state = sss_pkg::SSS_LOCKED_REGULATED;
        end
      end
      sss_pkg::SSS_SYNCED_HOLDOVER: begin
        if (rx_synced) begin
          next_state = sss_pkg::SSS_LOCKED_REGULATED;
        end else if (minute_tick && (hold_remain == 11'h001)) begin
          next_state = sss_pkg::SSS_CRYSTAL_FREEWHEEL;
        end
      end
      sss_pkg::SSS_CRYSTAL_SYNC_DELAY: begin
        if (!rx_synced) begin
          next_state = was_synced ? sss_pkg::SSS_CRYSTAL_FREEWHEEL
                                  : sss_pkg::SSS_CRYSTAL_SET_MANUALLY;
        end else if (lock_remain == 11'h000) begin
          next_state = sss_pkg::SSS_LOCKED_REGULATED;
        end
      end
      default: begin
        if (simulate && time_valid) begin
          next_state = sss_pkg::SSS_SYNCED_SIMULATED;
        end else if (rx_synced) begin
          next_state = sss_pkg::SSS_CRYSTAL_SYNC_DELAY;
        end else if (sync_state == sss_pkg::SSS_TIME_INVALID && time_valid) begin
          next_state = sss_pkg::SSS_CRYSTAL_SET_MANUALLY;
        end
      end
    endcase
    if (cmd_manual) begin
      next_state = sss_pkg::SSS_CRYSTAL_SET_MANUALLY;
    end
  end

  // module reset returns the time source to crystal set manually; it also restarts the init flag
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync_state <= sss_pkg::SSS_CRYSTAL_SET_MANUALLY;
      was_synced <= 1'b0;
    end else if (cmd_module_reset) begin
      sync_state <= sss_pkg::SSS_CRYSTAL_SET_MANUALLY;
      was_synced <= 1'b0;
    end else begin
      sync_state <= next_state;
      if (next_state == sss_pkg::SSS_LOCKED_REGULATED) begin
        was_synced <= 1'b1;
      end
    end
  end

  // minute timers; reloaded from the settings outside their state, stop at zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lock_remain <= '0;
      hold_remain <= '0;
    end else begin
      if (sync_state != sss_pkg::SSS_CRYSTAL_SYNC_DELAY) begin
        lock_remain <= lock_delay;
      end else if (minute_tick && (lock_remain != 11'h000)) begin
        lock_remain <= lock_remain - 11'h001;
      end
      if (sync_state != sss_pkg::SSS_SYNCED_HOLDOVER) begin
        hold_remain <= holdover;
      end else if (minute_tick && (hold_remain != 11'h000)) begin
        hold_remain <= hold_remain - 11'h001;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      status_output <= 1'b0;
    end else begin
      status_output <= (3'(next_state) <= threshold);
    end
  end

  // Read mux; timers read zero when idle
  always_comb begin
    next_rdata = 16'h0000;
    unique case (reg_addr)
      sss_pkg::SSS_REG_CONTROL: next_rdata = 16'(control);
      sss_pkg::SSS_REG_LOCK_DELAY: next_rdata = 16'(lock_delay);
      sss_pkg::SSS_REG_HOLDOVER: next_rdata = 16'(holdover);
      sss_pkg::SSS_REG_THRESHOLD: next_rdata = 16'(threshold);
      sss_pkg::SSS_REG_STATUS: next_rdata = 16'({error_collected, 3'(sync_state)});
      sss_pkg::SSS_REG_ERRORS: next_rdata = 16'(errors);
      sss_pkg::SSS_REG_LOCK_REMAIN: begin
        if (sync_state == sss_pkg::SSS_CRYSTAL_SYNC_DELAY) begin
          next_rdata = 16'(lock_remain);
        end
      end
      sss_pkg::SSS_REG_HOLD_REMAIN: begin
        if (sync_state == sss_pkg::SSS_SYNCED_HOLDOVER) begin
          next_rdata = 16'(hold_remain);
        end
      end
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

  // Assertions
  property p_threshold;
    @(posedge clock) disable iff (reset)
    1 |=> (status_output == (3'($past(next_state)) <= $past(threshold)));
  endproperty
  a_threshold: assert property (p_threshold) else $error("status output wrong");

  property p_withhold;
    @(posedge clock) disable iff (reset)
    (withhold && sync_state == sss_pkg::SSS_CRYSTAL_SET_MANUALLY && !simulate)
      |=> sync_state != sss_pkg::SSS_CRYSTAL_SYNC_DELAY;
  endproperty
  a_withhold: assert property (p_withhold) else $error("sync not withheld");

  property p_collect;
    @(posedge clock) disable iff (reset)
    (errors != '0) |-> error_collected;
  endproperty
  a_collect: assert property (p_collect) else $error("collected error missing");

  property p_hold_range;
    @(posedge clock) disable iff (reset)
    (holdover >= sss_pkg::SSS_HOLDOVER_MIN) && (holdover <= sss_pkg::SSS_HOLDOVER_MAX);
  endproperty
  a_hold_range: assert property (p_hold_range) else $error("holdover out of range");

  property p_refresh;
    @(posedge clock) disable iff (reset)
    !$past(refresh_tick) |-> $stable(errors);
  endproperty
  a_refresh: assert property (p_refresh) else $error("errors changed off refresh");

  property p_raw;
    @(posedge clock) disable iff (reset)
    errors[sss_pkg::SSS_ERR_RAW_DATA] |-> $past(receiving, 1) || !$past(refresh_tick);
  endproperty
  a_raw: assert property (p_raw) else $error("raw flag without reception");

  property p_manual;
    @(posedge clock) disable iff (reset)
    cmd_manual |=> sync_state == sss_pkg::SSS_CRYSTAL_SET_MANUALLY;
  endproperty
  a_manual: assert property (p_manual) else $error("manual set state wrong");

  property p_hold_cancel;
    @(posedge clock) disable iff (reset)
    (sync_state == sss_pkg::SSS_SYNCED_HOLDOVER && rx_synced && !cmd_manual && !cmd_module_reset)
      |=> sync_state == sss_pkg::SSS_LOCKED_REGULATED;
  endproperty
  a_hold_cancel: assert property (p_hold_cancel) else $error("holdover not cancelled");

endmodule

// [tb/sss_rx_model.sv]
// Receiver model: satellite count, sync and fault levels, registered
`timescale 1ns/1ps

module sss_rx_model (
  // Clock
  input wire logic clock,
  // Commands from the bench
  input wire logic [4:0] sats,
  input wire logic sync_req,
  input wire logic pos_chg,
  input wire logic [5:0] faults,
  // Report to the supervisor
  output sss_pkg::sss_rx_type rx
);
  // Levels change only after an edge, like a real serial decoder
  always_ff @(posedge clock) begin
    rx.sats_received <= sats;
    rx.receiver_sync <= sync_req;
    rx.position_changing <= pos_chg;
    rx.antenna_short <= faults[0];
    rx.antenna_open <= faults[1];
    rx.crystal_reg_fail <= faults[2];
    rx.general_module_fault <= faults[3];
    rx.port_setting_fault <= faults[4];
    rx.nonvolatile_store_fault <= faults[5];
  end
endmodule

// [tb/tb_top.sv]
// Testbench for the sync status supervisor
`timescale 1ns/1ps

module tb_top;
  logic clock, reset, reg_write, reg_read;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  sss_pkg::sss_rx_type rx;
  logic status_output, error_collected, source_reset, position_update;
  sss_pkg::sss_state_type sync_state;
  logic [4:0] sats;
  logic sync_req, pos_chg;
  logic [5:0] faults;
  int fails, cmp_count, seed, shadow[16];
  int err_bit[6] = '{6, 7, 5, 0, 4, 8};
  int hold_try[5] = '{1, 2, 1441, 1440, 2};

  sss_rx_model sss_rx_model_inst (.clock(clock), .sats(sats), .sync_req(sync_req),
    .pos_chg(pos_chg), .faults(faults), .rx(rx));
  // Short tick: minute is 600 cycles, refresh 50
  sss_supervisor #(.TICK_CYCLES(10)) sss_supervisor_inst (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .rx(rx), .status_output(status_output),
    .error_collected(error_collected), .source_reset(source_reset),
    .position_update(position_update), .sync_state(sync_state));

  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cs(input int st);
    chk({13'h0, sync_state}, st[15:0]);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Shadow keeps only values the register accepts
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    if (a == 4'h0) shadow[0] = v[4:0];
    if (a == 4'h1) shadow[1] = v[10:0];
    if (a == 4'h2 && v >= 2 && v <= 1440) shadow[2] = v;
    if (a == 4'h3 && v <= 6) shadow[3] = v;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rc(input logic [3:0] a);
    rd(a, d);
    chk(d, shadow[a][15:0]);
  endtask

  task automatic thr_sweep(input int st);
    for (int t = 0; t < 7; t++) begin
      wr(4'h3, t[15:0]);
      cyc(3);
      chk({15'h0, status_output}, {15'h0, st <= t});
    end
  endtask

  initial begin
    #400000;
    fails++;
    end_sim();
  end

  initial begin
    reset = 1;
    reg_addr = 0;
    reg_wdata = 0;
    reg_write = 0;
    reg_read = 0;
    sats = 0;
    sync_req = 0;
    pos_chg = 0;
    faults = 0;
    fails = 0;
    cmp_count = 0;
    seed = 32'h7cfc;
    shadow = '{default: 0};
    shadow[0] = 1;
    shadow[2] = 10;
    shadow[3] = 1;
    repeat (20) @(posedge clock);
    reset <= 0;
    cs(5);
    for (int a = 0; a < 4; a++) rc(a[3:0]);
    rc(4'h9);
    rc(4'hf);
    foreach (hold_try[i]) begin
      wr(4'h2, hold_try[i][15:0]);
      rc(4'h2);
    end
    wr(4'h3, 16'h0007);
    rc(4'h3);
    cyc(60);
    rd(4'h5, d);
    chk(d, 16'h000c);
    chk({15'h0, error_collected}, 16'h1);
    sats <= 6;
    sync_req <= 1;
    cyc(20);
    cs(5);
    wr(4'h0, 16'h0003);
    cyc(20);
    cs(5);
    pos_chg <= 1;
    wr(4'h0, 16'h0017);
    cyc(20);
    cs(5);
    pos_chg <= 0;
    cyc(20);
    cs(0);
    cyc(60);
    chk({15'h0, error_collected}, 16'h0);
    sats <= 3;
    cyc(5);
    cs(1);
    rd(4'h7, d);
    chk({15'h0, d != 0}, 16'h1);
    cyc(300);
    sats <= 6;
    cyc(20);
    cs(0);
    sync_req <= 0;
    cyc(5);
    thr_sweep(1);
    cyc(400);
    cs(1);
    cyc(800);
    cs(4);
    rc(4'h7);
    wr(4'h1, 16'h0001);
    sync_req <= 1;
    cyc(20);
    cs(3);
    rd(4'h6, d);
    chk({15'h0, d != 0}, 16'h1);
    cyc(700);
    cs(0);
    wr(4'h1, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      faults <= 6'h1 << i;
      cyc(60);
      rd(4'h5, d);
      chk(d, 16'h1 << err_bit[i]);
      chk({15'h0, error_collected}, 16'h1);
      faults <= 0;
      cyc(60);
    end
    for (int i = 0; i < 8; i++) begin
      sats <= 5'($unsigned($random(seed)) % 8);
      cyc(3);
      chk({15'h0, position_update}, {15'h0, sats >= 4});
    end
    sats <= 6;
    sync_req <= 0;
    cyc(10);
    @(posedge clock);
    reg_addr <= 4'h8;
    reg_wdata <= 16'h0001;
    reg_write <= 1'b1;
    #1 chk({15'h0, source_reset}, 16'h1);
    @(posedge clock);
    reg_write <= 1'b0;
    cyc(3);
    cs(5);
    rc(4'h0);
    rc(4'h2);
    thr_sweep(5);
    cyc(60);
    rd(4'h5, d);
    chk(d & 16'h0002, 16'h0002);
    cyc(700);
    rd(4'h5, d);
    chk(d & 16'h0002, 16'h0000);
    wr(4'h8, 16'h0002);
    rd(4'h0, d);
    chk(d & 16'h0006, 16'h0000);
    wr(4'h0, 16'h0017);
    sync_req <= 1;
    cyc(60);
    rd(4'h5, d);
    chk(d & 16'h0200, 16'h0200);
    sats <= 0;
    cyc(60);
    rd(4'h5, d);
    chk(d & 16'h0200, 16'h0000);
    sats <= 6;
    cyc(3600);
    chk({15'h0, sync_state == 3'd0}, 16'h0);
    cyc(5000);
    cs(0);
    sync_req <= 0;
    cyc(5);
    wr(4'h8, 16'h0004);
    cyc(3);
    cs(5);
    wr(4'h8, 16'h0008);
    cyc(60);
    rd(4'h5, d);
    chk(d & 16'h0002, 16'h0002);
    wr(4'h0, 16'h001f);
    cyc(3);
    cs(2);
    thr_sweep(2);
    end_sim();
  end
endmodule
